// file: design/hpsm_host_port.sv
/*
  Host port of the slot switch: bus type choice, banked registers,
  interrupt with masking, control memory, data memories, buffers,
  timer and clock source choice.
  Assumes host strobes already sampled into the core clock domain and
  the pcm bit clock given as a synchronous one-cycle tick.
*/
`default_nettype none
module hpsm_host_port
  import hpsm_pkg::*;
#(
  parameter int SLOTS = HPSM_SLOTS
)(
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Host bus.
  input  wire logic       chip_select_n,
  input  wire logic       addr_latch,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] data_in,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  output logic      [7:0] data_out,
  output logic            data_oe,
  output logic            irq_n,
  // Pcm and side port timing.
  input  wire logic       pcm_bit_clock,
  input  wire logic       pcm_frame_strobe,
  input  wire logic       side_slot_tick,
  input  wire logic       pcm_mode_redundant,
  input  wire logic       pcm_rx_main,
  input  wire logic       pcm_rx_spare,
  // Data paths.
  input  wire logic [7:0] pcm_rx_byte,
  output logic      [7:0] pcm_tx_byte,
  input  wire logic [7:0] side_rx_byte,
  output logic      [7:0] side_tx_byte,
  // Clock outputs and status.
  output logic            side_bit_clock,
  output logic            side_frame_strobe,
  output logic            side_clk_oe,
  output logic            multiframe_sync,
  output logic            reset_output_pulse,
  output logic      [1:0] bus_type
);
  localparam int SW = $clog2(SLOTS);

  typedef enum logic [1:0] {HPSM_ACC_IDLE, HPSM_ACC_BUSY} hpsm_acc_t;

  // Memories: control pointer and code, data memories both ways.
  logic [7:0] ctrl_mem [SLOTS];
  logic [1:0] code_mem [SLOTS];
  logic [7:0] up_mem   [SLOTS];
  logic [7:0] dn_mem   [SLOTS];

  // ==========================================================
  // Bus type choice
  // ==========================================================
  logic       latch_q;
  logic       reset_seen;
  hpsm_bus_t  bus, next_bus;
  hpsm_acc_t  acc, next_acc;
  logic [3:0] latched_addr, next_latched_addr;

  always_comb
  begin
    next_bus = bus;
    if (reset_seen)
      next_bus = addr_latch ? HPSM_BUS_MOTO : HPSM_BUS_INTEL_DEMUX;
    if (addr_latch != latch_q && !rst)
      next_bus = HPSM_BUS_INTEL_MUX;
    next_latched_addr = addr_latch ? addr : latched_addr;
  end

  // ==========================================================
  // Register access
  // ==========================================================
  logic [7:0] mode_reg, next_mode_reg;
  logic [7:0] config1, next_config1;
  logic [7:0] mask, next_mask;
  logic [7:0] cause, next_cause;
  logic [7:0] cm_addr, next_cm_addr;
  logic [6:0] timer_reload, next_timer_reload;
  logic [3:0] eff_addr;
  logic       bank;
  logic       rd_go, wr_go, mask_wr;
  logic [7:0] rd_val;
  logic [7:0] raw_events;
  logic [7:0] mon_rx_data, sig_data;
  logic       mon_full, mon_empty, sig_full, sig_empty;
  logic       mon_pop, sig_pop, mon_push, sig_push;

  always_comb
  begin
    eff_addr = (bus == HPSM_BUS_INTEL_MUX) ?
               {1'b0, latched_addr[3:1]} : addr;
    bank     = (bus != HPSM_BUS_INTEL_MUX) && mode_reg[HPSM_MODE_BANK_POS];
    rd_go    = !chip_select_n && !read_strobe_n && acc == HPSM_ACC_IDLE;
    wr_go    = !chip_select_n && !write_strobe_n && acc == HPSM_ACC_IDLE;
    next_acc = (!chip_select_n && (!read_strobe_n || !write_strobe_n)) ?
               HPSM_ACC_BUSY : HPSM_ACC_IDLE;
    mask_wr  = !chip_select_n && !write_strobe_n && !bank &&
               eff_addr == HPSM_OFS_MASK;
    next_mode_reg     = mode_reg;
    next_config1      = config1;
    next_mask         = mask;
    next_cm_addr      = cm_addr;
    next_timer_reload = timer_reload;
    mon_pop = 1'b0;
    sig_pop = 1'b0;
    rd_val  = 8'h00;
    if (eff_addr == HPSM_OFS_MODE)
      rd_val = mode_reg;
    else if (bank && eff_addr == HPSM_OFS_CONFIG1)
      rd_val = config1;
    else if (bank && eff_addr == HPSM_OFS_TIMER)
      rd_val = {1'b0, timer_reload};
    else if (!bank && eff_addr == HPSM_OFS_STATUS)
      rd_val = cause;
    else if (!bank && eff_addr == HPSM_OFS_MASK)
      rd_val = mask;
    else if (!bank && eff_addr == HPSM_OFS_CMADDR)
      rd_val = cm_addr;
    else if (!bank && eff_addr == HPSM_OFS_CMDATA)
      rd_val = ctrl_mem[cm_addr[SW-1:0]];
    else if (!bank && eff_addr == HPSM_OFS_CMCODE)
      rd_val = {6'h00, code_mem[cm_addr[SW-1:0]]};
    else if (!bank && eff_addr == HPSM_OFS_MONFIFO)
      rd_val = mon_rx_data;
    else if (!bank && eff_addr == HPSM_OFS_SIGFIFO)
      rd_val = sig_data;
    if (rd_go && !bank)
    begin
      mon_pop = eff_addr == HPSM_OFS_MONFIFO;
      sig_pop = eff_addr == HPSM_OFS_SIGFIFO;
    end
    if (wr_go)
    begin
      if (eff_addr == HPSM_OFS_MODE)
        next_mode_reg = data_in;
      else if (bank && eff_addr == HPSM_OFS_CONFIG1)
        next_config1 = data_in;
      else if (bank && eff_addr == HPSM_OFS_TIMER)
        next_timer_reload = data_in[6:0];
      else if (!bank && eff_addr == HPSM_OFS_MASK)
        next_mask = data_in;
      else if (!bank && eff_addr == HPSM_OFS_CMADDR)
        next_cm_addr = data_in;
    end
    mon_push = wr_go && !bank && eff_addr == HPSM_OFS_MONFIFO;
    // Set wins over read-clear; masked sources never show.
    next_cause = (rd_go && !bank && eff_addr == HPSM_OFS_STATUS) ?
                 8'h00 : cause;
    next_cause = (next_cause | raw_events) & ~next_mask;
  end

  // ==========================================================
  // Timer, prescaler, signaling, redundancy
  // ==========================================================
  logic [6:0] timer, next_timer;
  logic [3:0] presc, next_presc;
  logic [7:0] slot, next_slot;
  logic [7:0] side_slot, next_side_slot;
  logic [7:0] sig_cand, next_sig_cand;
  logic       look_armed, next_look_armed;
  logic       timer_hit;
  logic [SW-1:0] sp;

  always_comb
  begin
    timer_hit  = pcm_bit_clock && timer == 7'h00;
    next_timer = timer;
    if (pcm_bit_clock)
      next_timer = timer_hit ? timer_reload : timer - 7'h01;
    next_presc = presc;
    if (pcm_bit_clock)
      next_presc = (presc == HPSM_PRESCALE) ? 4'h0 : presc + 4'h1;
    next_slot = slot;
    if (pcm_frame_strobe)
      next_slot = 8'h00;
    else if (pcm_bit_clock)
      next_slot = (slot == 8'(SLOTS - 1)) ? 8'h00 : slot + 8'h01;
    next_side_slot = side_slot;
    if (side_slot_tick)
      next_side_slot = (side_slot == 8'(SLOTS - 1)) ?
                       8'h00 : side_slot + 8'h01;
    sp = side_slot[SW-1:0];
    next_sig_cand   = sig_cand;
    next_look_armed = look_armed;
    sig_push        = 1'b0;
    raw_events      = 8'h00;
    if (side_slot_tick && code_mem[sp] != HPSM_CODE_SWITCH &&
        side_rx_byte != ctrl_mem[sp])
    begin
      // Second look must agree and fall on a timer expiry before taking it.
      if (!config1[HPSM_CFG_SIG8_POS] ||
          (look_armed && sig_cand == side_rx_byte && timer_hit))
      begin
        sig_push        = !sig_full;
        next_look_armed = 1'b0;
        raw_events[HPSM_IRQ_SIG_POS] = 1'b1;
      end
      else
      begin
        next_sig_cand   = side_rx_byte;
        next_look_armed = 1'b1;
      end
    end
    raw_events[HPSM_IRQ_TIMER_POS]  = timer_hit;
    raw_events[HPSM_IRQ_MON_POS]    = !mon_empty &&
                                      config1[HPSM_CFG_HSHAKE_POS];
    raw_events[HPSM_IRQ_REDUND_POS] = pcm_mode_redundant &&
      config1[HPSM_CFG_REDUND_POS] && pcm_rx_main != pcm_rx_spare;
  end

  hpsm_fifo #(.WIDTH(8), .DEPTH(HPSM_MON_DEPTH)) u_mon_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .push      (mon_push),
    .push_data (data_in),
    .pop       (mon_pop),
    .pop_data  (mon_rx_data),
    .full      (mon_full),
    .empty     (mon_empty)
  );

  hpsm_fifo #(.WIDTH(8), .DEPTH(HPSM_SIG_DEPTH)) u_sig_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .push      (sig_push),
    .push_data (side_slot),
    .pop       (sig_pop),
    .pop_data  (sig_data),
    .full      (sig_full),
    .empty     (sig_empty)
  );

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge core_clk)
  begin
    latch_q    <= addr_latch;
    reset_seen <= rst;
    if (rst)
    begin
      bus          <= HPSM_BUS_MOTO;
      acc          <= HPSM_ACC_IDLE;
      latched_addr <= 4'h0;
      mode_reg     <= HPSM_MODE_RST;
      config1      <= HPSM_CONFIG_RST;
      mask         <= HPSM_MASK_RST;
      cause        <= 8'h00;
      cm_addr      <= 8'h00;
      timer_reload <= HPSM_TIMER_RST;
      timer        <= HPSM_TIMER_RST;
      presc        <= 4'h0;
      slot         <= 8'h00;
      side_slot    <= 8'h00;
      sig_cand     <= 8'h00;
      look_armed   <= 1'b0;
      data_out     <= 8'h00;
      data_oe      <= 1'b0;
      irq_n        <= 1'b1;
      pcm_tx_byte  <= 8'h00;
      side_tx_byte <= 8'h00;
      side_bit_clock     <= 1'b0;
      side_frame_strobe  <= 1'b0;
      side_clk_oe        <= 1'b0;
      multiframe_sync    <= 1'b0;
      reset_output_pulse <= 1'b0;
      bus_type     <= 2'h0;
    end
    else
    begin
      bus          <= next_bus;
      acc          <= next_acc;
      latched_addr <= next_latched_addr;
      mode_reg     <= next_mode_reg;
      config1      <= next_config1;
      mask         <= next_mask;
      cause        <= next_cause;
      cm_addr      <= next_cm_addr;
      timer_reload <= next_timer_reload;
      timer        <= next_timer;
      presc        <= next_presc;
      slot         <= next_slot;
      side_slot    <= next_side_slot;
      sig_cand     <= next_sig_cand;
      look_armed   <= next_look_armed;
      data_out     <= rd_val;
      data_oe      <= !chip_select_n && !read_strobe_n;
      irq_n        <= !(next_cause != 8'h00) || mask_wr;
      pcm_tx_byte  <= up_mem[slot[SW-1:0]];
      side_tx_byte <= (code_mem[sp] == HPSM_CODE_SWITCH) ?
                      dn_mem[ctrl_mem[sp][SW-1:0]] : ctrl_mem[sp];
      side_bit_clock     <= (presc == 4'h0);
      side_frame_strobe  <= pcm_frame_strobe;
      side_clk_oe        <= !config1[HPSM_CFG_CSS_POS];
      multiframe_sync    <= timer_hit;
      reset_output_pulse <= timer != 7'h00 && mode_reg[7];
      bus_type     <= 2'(bus);
    end
  end

  // Memories carry no reset; the host must initialise control memory.
  always_ff @(posedge core_clk)
  begin
    if (pcm_bit_clock)
      dn_mem[slot[SW-1:0]] <= pcm_rx_byte;
    if (side_slot_tick && code_mem[sp] == HPSM_CODE_SWITCH)
      up_mem[ctrl_mem[sp][SW-1:0]] <= side_rx_byte;
    if (sig_push)
      ctrl_mem[sp] <= side_rx_byte;
    else if (wr_go && !bank && eff_addr == HPSM_OFS_CMDATA)
      ctrl_mem[cm_addr[SW-1:0]] <= data_in;
    if (wr_go && !bank && eff_addr == HPSM_OFS_CMCODE)
      code_mem[cm_addr[SW-1:0]] <= data_in[1:0];
  end
endmodule
`default_nettype wire

// file: design/hpsm_pkg.sv
/*
  Constants and types shared by the host port of the slot switch.
  Assumes a single core clock domain at 250 MHz.
*/
`default_nettype none
package hpsm_pkg;
  // Bus type chosen from the address latch pin.
  typedef enum logic [1:0] {
    HPSM_BUS_MOTO,
    HPSM_BUS_INTEL_DEMUX,
    HPSM_BUS_INTEL_MUX
  } hpsm_bus_t;

  // Register indices inside a bank (4 address lines).
  localparam logic [3:0] HPSM_OFS_STATUS  = 4'h0;
  localparam logic [3:0] HPSM_OFS_MASK    = 4'h1;
  localparam logic [3:0] HPSM_OFS_CMADDR  = 4'h2;
  localparam logic [3:0] HPSM_OFS_CMDATA  = 4'h3;
  localparam logic [3:0] HPSM_OFS_CMCODE  = 4'h4;
  localparam logic [3:0] HPSM_OFS_MONFIFO = 4'h5;
  localparam logic [3:0] HPSM_OFS_SIGFIFO = 4'h6;
  localparam logic [3:0] HPSM_OFS_MODE    = 4'hf;
  localparam logic [3:0] HPSM_OFS_CONFIG1 = 4'h1;
  localparam logic [3:0] HPSM_OFS_TIMER   = 4'h2;

  // Field positions.
  localparam int HPSM_MODE_BANK_POS   = 0;
  localparam int HPSM_CFG_CSS_POS     = 0;
  localparam int HPSM_CFG_REDUND_POS  = 1;
  localparam int HPSM_CFG_SIG8_POS    = 2;
  localparam int HPSM_CFG_HSHAKE_POS  = 3;
  localparam int HPSM_IRQ_SIG_POS     = 0;
  localparam int HPSM_IRQ_TIMER_POS   = 1;
  localparam int HPSM_IRQ_MON_POS     = 2;
  localparam int HPSM_IRQ_REDUND_POS  = 3;

  // Reset values.
  localparam logic [7:0] HPSM_MODE_RST   = 8'h00;
  localparam logic [7:0] HPSM_CONFIG_RST = 8'h00;
  localparam logic [7:0] HPSM_MASK_RST   = 8'hff;
  localparam logic [6:0] HPSM_TIMER_RST  = 7'h7f;

  // Control memory code values.
  localparam logic [1:0] HPSM_CODE_SWITCH = 2'h0;
  localparam logic [1:0] HPSM_CODE_SIGNAL = 2'h1;
  localparam logic [1:0] HPSM_CODE_CMDIND = 2'h2;

  // Sizes.
  localparam int HPSM_MON_DEPTH = 16;
  localparam int HPSM_SIG_DEPTH = 9;
  localparam int HPSM_SLOTS     = 128;

  // Divider from pcm bit clock to side bit clock.
  localparam logic [3:0] HPSM_PRESCALE = 4'h1;
endpackage
`default_nettype wire

// file: design/hpsm_fifo.sv
/*
  Small byte FIFO used for the monitor and signaling buffers.
  Assumes push is never given while full and pop never while empty.
*/
`default_nettype none
module hpsm_fifo
  import hpsm_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)(
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Fill side.
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  // Drain side.
  input  wire logic             pop,
  output logic      [WIDTH-1:0] pop_data,
  // Status.
  output logic                  full,
  output logic                  empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             do_push;
  logic             do_pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1))
      return '0;
    return p + 1'b1;
  endfunction

  always_comb
  begin
    do_push     = push && !full;
    do_pop      = pop && !empty;
    next_wr_ptr = do_push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = do_pop ? bump(rd_ptr) : rd_ptr;
    next_count  = count + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
    if (do_push)
      mem[wr_ptr] <= push_data;
  end

  assign pop_data = mem[rd_ptr];
  assign full     = (count == (AW+1)'(DEPTH));
  assign empty    = (count == '0);
endmodule
`default_nettype wire

// file: dv/hpsm_host_port_checker.sv
/*
  Checker for the host port of the slot switch: bus type choice,
  interrupt line and read drive, seen at the top module's ports.
  Assumes one core clock and a synchronous active-high reset.
*/
`default_nettype none
module hpsm_host_port_checker
  import hpsm_pkg::*;
#(
  parameter int SLOTS = HPSM_SLOTS
)(
  // Clock and reset.
  input wire logic       core_clk,
  input wire logic       rst,
  // Host bus.
  input wire logic       chip_select_n,
  input wire logic       addr_latch,
  input wire logic [3:0] addr,
  input wire logic [7:0] data_in,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic       data_oe,
  input wire logic       irq_n,
  input wire logic [1:0] bus_type
);
  // ==========================================================
  // Bank and mask write tracking
  logic bank;
  logic next_bank;
  logic mask_seen;
  logic next_mask_seen;
  logic host_wr;

  // Multiplexed writes are left out: their index is latched, not on addr.
  assign host_wr = !chip_select_n && !write_strobe_n &&
                   bus_type != HPSM_BUS_INTEL_MUX;

  always_comb
  begin
    next_bank      = bank;
    next_mask_seen = mask_seen;
    if (host_wr && addr == HPSM_OFS_MODE)
      next_bank = data_in[HPSM_MODE_BANK_POS];
    if (host_wr && addr == HPSM_OFS_MASK && !bank)
      next_mask_seen = 1'b1;
    if (rst)
    begin
      next_bank      = 1'b0;
      next_mask_seen = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    bank      <= next_bank;
    mask_seen <= next_mask_seen;
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  bus_pick_a: assert property ($fell(rst) |-> ##[1:2]
    bus_type == (addr_latch ? HPSM_BUS_MOTO : HPSM_BUS_INTEL_DEMUX))
    else $error("bus type not taken from latch level at reset");
  mux_stays_a: assert property (bus_type == HPSM_BUS_INTEL_MUX |=>
    bus_type == HPSM_BUS_INTEL_MUX)
    else $error("bus type left multiplexed without reset");
  latch_edge_a: assert property (!$past(rst) && $changed(addr_latch)
    |-> ##[0:3] bus_type == HPSM_BUS_INTEL_MUX)
    else $error("latch edge did not select multiplexed bus");
  mask_write_a: assert property (host_wr && addr == HPSM_OFS_MASK
    && !bank |=> irq_n)
    else $error("interrupt active during mask write");
  read_drive_a: assert property (!chip_select_n && !read_strobe_n
    |=> data_oe)
    else $error("read data not driven");
  cs_idle_a: assert property (chip_select_n |=> !data_oe)
    else $error("read data driven without chip select");
  masked_idle_a: assert property (!mask_seen |-> irq_n)
    else $error("interrupt active while all sources masked");
  irq_hold_a: assert property (!irq_n && (chip_select_n ||
    (read_strobe_n && write_strobe_n)) |=> !irq_n)
    else $error("interrupt released without host service");

  cover property (!irq_n);
  cover property (bus_type == HPSM_BUS_INTEL_MUX);
  cover property (host_wr && addr == HPSM_OFS_MASK && !bank && !irq_n);
endmodule

bind hpsm_host_port hpsm_host_port_checker #(.SLOTS(SLOTS))
  hpsm_host_port_checker_inst (
  .core_clk       (core_clk),
  .rst            (rst),
  .chip_select_n  (chip_select_n),
  .addr_latch     (addr_latch),
  .addr           (addr),
  .data_in        (data_in),
  .read_strobe_n  (read_strobe_n),
  .write_strobe_n (write_strobe_n),
  .data_oe        (data_oe),
  .irq_n          (irq_n),
  .bus_type       (bus_type)
);
`default_nettype wire

// file: dv/hpsm_host_model.sv
/*
  Byte-wide host processor model driving the host port.
  Assumes the bench calls its access task from one process only.
*/
`default_nettype none
module hpsm_host_model
  import hpsm_pkg::*;
(
  // Clock and read data.
  input  wire logic       core_clk,
  input  wire logic [7:0] data_out,
  // Bus drive.
  output var logic        chip_select_n,
  output var logic        addr_latch,
  output var logic  [3:0] addr,
  output var logic  [7:0] data_in,
  output var logic        read_strobe_n,
  output var logic        write_strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mux_mode;

  initial
  begin
    chip_select_n  = 1'b1;
    addr_latch     = 1'b0;
    addr           = 4'h0;
    data_in        = 8'h00;
    read_strobe_n  = 1'b1;
    write_strobe_n = 1'b1;
    mux_mode       = 1'b0;
  end

  // The strobe covers one rising edge, at which the port takes the
  // access. The registered answer is read at the next falling edge,
  // where it has settled, and the bus is released at that same point.
  task automatic access(input logic [3:0] ofs, input logic wr_en,
                        input logic [7:0] wdata, input logic cs,
                        output logic [7:0] rdata);
    @(negedge core_clk);
    addr = ofs;
    if (mux_mode)
    begin
      addr       = {ofs[2:0], 1'b0};
      addr_latch = 1'b1;
      @(negedge core_clk);
      addr_latch = 1'b0;
    end
    data_in        = wdata;
    chip_select_n  = !cs;
    read_strobe_n  = wr_en;
    write_strobe_n = !wr_en;
    @(posedge core_clk);
    @(negedge core_clk);
    rdata = data_out;
    chip_select_n  = 1'b1;
    read_strobe_n  = 1'b1;
    write_strobe_n = 1'b1;
    data_in        = ~wdata;
  endtask
endmodule
`default_nettype wire

// file: dv/hpsm_host_port_tb.sv
/*
  Self-checking bench for the host port of the slot switch.
  Assumes the host model and the bound checker are compiled alongside.
*/
`default_nettype none
module hpsm_host_port_tb;
  import hpsm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] RED_BIT = 8'h01 << HPSM_IRQ_REDUND_POS;
  localparam logic [7:0] CFG_VAL = (8'h01 << HPSM_CFG_CSS_POS) |
                                   (8'h01 << HPSM_CFG_REDUND_POS);
  // Line stimulus starts known so that a clock edge at time zero
  // cannot toggle it from an unknown value.
  logic       core_clk, rst;
  logic       pcm_bit_clock = 1'b0;
  logic       pcm_frame_strobe = 1'b0;
  logic [7:0] pcm_rx_byte = 8'h00;
  logic [7:0] side_rx_byte = 8'h00;
  logic       pcm_mode_redundant, pcm_rx_main, pcm_rx_spare;
  logic       chip_select_n, addr_latch, read_strobe_n, write_strobe_n;
  logic       irq_n, side_clk_oe;
  logic [3:0] addr;
  logic [7:0] data_in, data_out;
  logic [1:0] bus_type;
  int         fail_count = 0;
  int         comparisons = 0;
  int         cycles = 0;

  hpsm_host_model hpsm_host_model_inst (.core_clk(core_clk),
    .data_out(data_out), .chip_select_n(chip_select_n),
    .addr_latch(addr_latch), .addr(addr), .data_in(data_in),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n));

  hpsm_host_port hpsm_host_port_inst (.core_clk(core_clk), .rst(rst),
    .chip_select_n(chip_select_n), .addr_latch(addr_latch), .addr(addr),
    .data_in(data_in), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .data_out(data_out), .data_oe(),
    .irq_n(irq_n), .pcm_bit_clock(pcm_bit_clock),
    .pcm_frame_strobe(pcm_frame_strobe),
    .side_slot_tick(pcm_bit_clock),
    .pcm_mode_redundant(pcm_mode_redundant), .pcm_rx_main(pcm_rx_main),
    .pcm_rx_spare(pcm_rx_spare), .pcm_rx_byte(pcm_rx_byte),
    .pcm_tx_byte(), .side_rx_byte(side_rx_byte), .side_tx_byte(),
    .side_bit_clock(), .side_frame_strobe(), .side_clk_oe(side_clk_oe),
    .multiframe_sync(), .reset_output_pulse(), .bus_type(bus_type));

  // ==========================================================
  // Clock, line traffic and hang guard
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(negedge core_clk)
  begin
    pcm_bit_clock    <= ~pcm_bit_clock;
    pcm_rx_byte      <= pcm_rx_byte + 8'h01;
    side_rx_byte     <= side_rx_byte - 8'h01;
    pcm_frame_strobe <= (pcm_rx_byte[5:0] == 6'h3f);
  end

  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      fail_count = fail_count + 1;
      report_and_stop();
    end
  end

  // ==========================================================
  // Access and compare tasks
  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] ofs, input logic [7:0] v);
    logic [7:0] d;
    hpsm_host_model_inst.access(ofs, 1'b1, v, 1'b1, d);
  endtask

  task automatic rd_chk(input logic [3:0] ofs, input logic [7:0] exp,
                        input string name);
    logic [7:0] d;
    hpsm_host_model_inst.access(ofs, 1'b0, 8'h00, 1'b1, d);
    chk(name, exp, d);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    int i;
    logic [7:0] d;
    rst = 1'b1;
    pcm_mode_redundant = 1'b1;
    pcm_rx_main = 1'b0;
    pcm_rx_spare = 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("bus_type", 8'h01, {6'h00, bus_type});
    chk("irq_n", 8'h01, {7'h00, irq_n});
    chk("side_clk_oe", 8'h01, {7'h00, side_clk_oe});
    rd_chk(HPSM_OFS_MASK, HPSM_MASK_RST, "mask");
    rd_chk(HPSM_OFS_MODE, HPSM_MODE_RST, "mode");
    wr(HPSM_OFS_MODE, 8'h01);
    wr(HPSM_OFS_CONFIG1, CFG_VAL);
    rd_chk(HPSM_OFS_MODE, 8'h01, "mode_bank1");
    rd_chk(HPSM_OFS_CONFIG1, CFG_VAL, "config");
    chk("side_clk_in", 8'h00, {7'h00, side_clk_oe});
    wr(HPSM_OFS_MODE, 8'h00);
    rd_chk(HPSM_OFS_MASK, 8'hff, "mask_bank0");
    // Main and spare lines now disagree.
    pcm_rx_main = 1'b1;
    repeat (8) @(negedge core_clk);
    chk("irq_n_masked", 8'h01, {7'h00, irq_n});
    rd_chk(HPSM_OFS_STATUS, 8'h00, "status_masked");
    wr(HPSM_OFS_MASK, ~RED_BIT);
    for (i = 0; i < 16 && irq_n !== 1'b0; i++)
      @(negedge core_clk);
    chk("irq_n_raised", 8'h00, {7'h00, irq_n});
    rd_chk(HPSM_OFS_STATUS, RED_BIT, "status_cause");
    wr(HPSM_OFS_MASK, ~RED_BIT);
    repeat (4) @(negedge core_clk);
    chk("irq_n_pending", 8'h00, {7'h00, irq_n});
    pcm_rx_main = 1'b0;
    repeat (4) @(negedge core_clk);
    rd_chk(HPSM_OFS_STATUS, RED_BIT, "status_last");
    rd_chk(HPSM_OFS_STATUS, 8'h00, "status_clear");
    chk("irq_n_served", 8'h01, {7'h00, irq_n});
    hpsm_host_model_inst.access(HPSM_OFS_MASK, 1'b1, 8'h00, 1'b0, d);
    rd_chk(HPSM_OFS_MASK, ~RED_BIT, "mask_no_cs");
    wr(HPSM_OFS_CMADDR, 8'h05);
    wr(HPSM_OFS_CMDATA, 8'h2a);
    wr(HPSM_OFS_CMCODE, {6'h00, HPSM_CODE_CMDIND});
    rd_chk(HPSM_OFS_CMDATA, 8'h2a, "cm_data");
    rd_chk(HPSM_OFS_CMCODE, {6'h00, HPSM_CODE_CMDIND}, "cm_code");
    hpsm_host_model_inst.mux_mode = 1'b1;
    rd_chk(HPSM_OFS_MASK, ~RED_BIT, "mask_mux");
    chk("bus_type_mux", 8'h02, {6'h00, bus_type});
    hpsm_host_model_inst.mux_mode = 1'b0;
    rst = 1'b1;
    hpsm_host_model_inst.addr_latch = 1'b1;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("bus_type_moto", 8'h00, {6'h00, bus_type});
    rd_chk(HPSM_OFS_MASK, HPSM_MASK_RST, "mask_after_reset");
    report_and_stop();
  end
endmodule
`default_nettype wire
